// File: ipr_map.vh
// Purpose: constants for the priority register six block
// Assumes: included by the register block and its field module
// Notes: offsets are byte addresses on the register bus
`ifndef IPR_MAP_VH
`define IPR_MAP_VH
`define IPR_OFF_PRIO6 12'h000
`define IPR_ADDR_W 12
`define IPR_FLD_W 3
`define IPR_FLD_RST 3'h4
`define IPR_FLD_OFF 3'h0
`define IPR_TX_LSB 12
`define IPR_RX_LSB 8
`define IPR_EXT2_LSB 4
`define IPR_TMR5_LSB 0
`define IPR_REG_W 16
`define IPR_MASK 16'h7777
`define IPR_HTRANS_NONSEQ 2'h2
`define IPR_HTRANS_SEQ 2'h3
`define IPR_HSIZE_WORD 3'h2
`endif

// File: ipr_prio_field.v
// Purpose: one 3-bit priority field with its request gate
// Assumes: write strobe and data from the same clock domain
// Notes: code zero masks the source entirely
`timescale 1ns/1ps
`include "ipr_map.vh"
module ipr_prio_field #(
    parameter FLD_W = `IPR_FLD_W,
    parameter [FLD_W-1:0] RST_VAL = `IPR_FLD_RST
) (
    input wire clk_sys,
    input wire nrst,
    input wire wrEn,
    input wire [FLD_W-1:0] wrData,
    input wire srcPending,
    output reg [FLD_W-1:0] level_q,
    output wire srcRequest
);
    // ----------------------------------------
    // field storage
    // ----------------------------------------
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            level_q <= RST_VAL;
        end else if (wrEn) begin
            level_q <= wrData;
        end
    end

    // ----------------------------------------
    // request gate
    // ----------------------------------------
    // level zero disables the source
    assign srcRequest = srcPending && (level_q != `IPR_FLD_OFF);
endmodule // ipr_prio_field

// File: ipr_prio_reg6.v
// Purpose: priority register six, AHB-Lite slave, four fields
// Assumes: single clock, one word per register
// Notes: zero wait states; response always OKAY;
//   a write lands at the end of its data phase;
//   a read returns the image sampled in its address phase
`timescale 1ns/1ps
`include "ipr_map.vh"
module ipr_prio_reg6 #(
    parameter ADDR_W = `IPR_ADDR_W,
    parameter FLD_W = `IPR_FLD_W,
    parameter REG_W = `IPR_REG_W
) (
    input wire clk_sys,
    input wire nrst,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output reg [31:0] hrdata,
    input wire txPending,
    input wire rxPending,
    input wire ext2Pending,
    input wire tmr5Pending,
    output wire [2:0] serial2TxIrqPriority,
    output wire [2:0] serial2RxIrqPriority,
    output wire [2:0] extInput2IrqPriority,
    output wire [2:0] timer5IrqPriority,
    output wire txRequest,
    output wire rxRequest,
    output wire ext2Request,
    output wire tmr5Request
);
    // ----------------------------------------
    // declarations
    // ----------------------------------------
    // address phase decode
    wire transValid;
    wire accValid;
    wire hitReg;
    wire wrAccess;
    wire rdAccess;
    // data phase write control
    reg wrPend_q;
    reg wrPend_d;
    wire wrThis;
    // write data slices, one per field
    wire [FLD_W-1:0] txWrData;
    wire [FLD_W-1:0] rxWrData;
    wire [FLD_W-1:0] ext2WrData;
    wire [FLD_W-1:0] tmr5WrData;
    // read side
    wire [REG_W-1:0] regView;
    reg [31:0] rdData_d;
    // request gating lives inside each field instance

    // ----------------------------------------
    // address phase decode
    // ----------------------------------------
    // a transfer is live on NONSEQ or SEQ with the bus ready
    assign transValid = (htrans == `IPR_HTRANS_NONSEQ)
        || (htrans == `IPR_HTRANS_SEQ);
    assign accValid = hsel && hready && transValid;
    // only the low address bits select the register, so it
    // aliases throughout the slave's address window;
    // hsize is taken as a whole word and not checked
    assign hitReg = (haddr[ADDR_W-1:0] == `IPR_OFF_PRIO6);
    assign wrAccess = accValid && hwrite && hitReg;
    assign rdAccess = accValid && !hwrite && hitReg;

    // ----------------------------------------
    // response
    // ----------------------------------------
    // no wait states and no error response;
    // a single slave with no stall needs no wait logic
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // ----------------------------------------
    // data phase write control
    // ----------------------------------------
    // a taken write stays pending while the bus stalls;
    // a new address phase replaces it once hready is high
    always @* begin
        wrPend_d = wrPend_q;
        if (hready) begin
            wrPend_d = wrAccess;
        end
    end

    // pending write flag, cleared by reset
    // so no stray write follows a reset
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wrPend_q <= 1'b0;
        end else begin
            wrPend_q <= wrPend_d;
        end
    end

    // write strobe at the end of the data phase; a read in
    // that same cycle still sees the old fields
    assign wrThis = wrPend_q && hready;

    // ----------------------------------------
    // write data slices
    // ----------------------------------------
    // spare bits are never taken, so writes to them vanish
    assign txWrData = hwdata[`IPR_TX_LSB +: FLD_W];
    assign rxWrData = hwdata[`IPR_RX_LSB +: FLD_W];
    assign ext2WrData = hwdata[`IPR_EXT2_LSB +: FLD_W];
    assign tmr5WrData = hwdata[`IPR_TMR5_LSB +: FLD_W];

    // ----------------------------------------
    // priority fields
    // ----------------------------------------
    // four identical fields; each gates its own request
    // transmitter field
    ipr_prio_field #(
        .FLD_W(FLD_W),
        .RST_VAL(`IPR_FLD_RST)
    ) uTx (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .wrEn(wrThis),
        .wrData(txWrData),
        .srcPending(txPending),
        .level_q(serial2TxIrqPriority),
        .srcRequest(txRequest)
    );

    // receiver field
    ipr_prio_field #(
        .FLD_W(FLD_W),
        .RST_VAL(`IPR_FLD_RST)
    ) uRx (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .wrEn(wrThis),
        .wrData(rxWrData),
        .srcPending(rxPending),
        .level_q(serial2RxIrqPriority),
        .srcRequest(rxRequest)
    );

    // external input 2 field
    ipr_prio_field #(
        .FLD_W(FLD_W),
        .RST_VAL(`IPR_FLD_RST)
    ) uExt2 (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .wrEn(wrThis),
        .wrData(ext2WrData),
        .srcPending(ext2Pending),
        .level_q(extInput2IrqPriority),
        .srcRequest(ext2Request)
    );

    // timer 5 field
    ipr_prio_field #(
        .FLD_W(FLD_W),
        .RST_VAL(`IPR_FLD_RST)
    ) uTmr5 (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .wrEn(wrThis),
        .wrData(tmr5WrData),
        .srcPending(tmr5Pending),
        .level_q(timer5IrqPriority),
        .srcRequest(tmr5Request)
    );

    // ----------------------------------------
    // read image
    // ----------------------------------------
    // fields at fixed places, spares forced to zero by mask
    assign regView = {1'b0, serial2TxIrqPriority, 1'b0,
        serial2RxIrqPriority, 1'b0, extInput2IrqPriority, 1'b0,
        timer5IrqPriority} & `IPR_MASK;

    // ----------------------------------------
    // read data
    // ----------------------------------------
    // next read word: register hit, unmapped zero, else hold;
    // a write hit also clears it, which no master reads
    always @* begin
        rdData_d = hrdata;
        if (rdAccess) begin
            rdData_d = {{(32-REG_W){1'b0}}, regView};
        end else if (accValid) begin
            rdData_d = 32'h00000000; // unmapped reads zero
        end
    end

    // read data registered for the data phase;
    // it stands until the next accepted transfer
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            hrdata <= 32'h00000000;
        end else begin
            hrdata <= rdData_d;
        end
    end

endmodule // ipr_prio_reg6

// File: ipr_prio_reg6_chk.sv
// Purpose: port checker for priority register six
// Assumes: zero wait states, register at offset 0
// Notes: bound to every instance of the register block
`timescale 1ns/1ps
module ipr_prio_reg6_chk (
    input wire clk_sys, input wire nrst, input wire hsel, input wire hwrite,
    input wire [31:0] haddr, input wire [1:0] htrans, input wire hready,
    input wire [31:0] hwdata, input wire [31:0] hrdata,
    input wire txPending, input wire rxPending,
    input wire ext2Pending, input wire tmr5Pending,
    input wire [2:0] serial2TxIrqPriority, input wire [2:0] serial2RxIrqPriority,
    input wire [2:0] extInput2IrqPriority, input wire [2:0] timer5IrqPriority,
    input wire txRequest, input wire rxRequest,
    input wire ext2Request, input wire tmr5Request
);
    // packed fields, write data fields and read image
    wire [11:0] f = {serial2TxIrqPriority, serial2RxIrqPriority,
        extInput2IrqPriority, timer5IrqPriority};
    wire [11:0] wf = {hwdata[14:12], hwdata[10:8], hwdata[6:4], hwdata[2:0]};
    wire [31:0] rv = {17'h0, f[11:9], 1'b0, f[8:6], 1'b0, f[5:3], 1'b0, f[2:0]};
    wire acc = hsel && hready && htrans[1] && haddr[11:0] == 12'h000;
    wire wacc = acc && hwrite;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    fields_write_a: assert property (wacc |=> ##1 f == $past(wf))
        else $error("field write lost");
    read_back_a: assert property (acc && !hwrite |=> hrdata == $past(rv))
        else $error("read data wrong");
    unused_zero_a: assert property ((hrdata & 32'hFFFF8888) == 32'h0)
        else $error("unused bit set");
    req_gate_a: assert property ({txRequest, rxRequest, ext2Request,
        tmr5Request} == {txPending && |f[11:9], rxPending && |f[8:6],
        ext2Pending && |f[5:3], tmr5Pending && |f[2:0]})
        else $error("request gate wrong");
    reset_val_a: assert property ($rose(nrst) |-> f == 12'h924)
        else $error("reset field value");
    field_hold_a: assert property (!$past(wacc, 2) |-> $stable(f))
        else $error("field changed unwritten");
endmodule // ipr_prio_reg6_chk
bind ipr_prio_reg6 ipr_prio_reg6_chk chk_u (.*);

// File: ipr_prio_reg6_tb_top.sv
// Purpose: self-checking bench for priority register six
// Assumes: hready tied to hreadyout, all sources pending except while t_gate_rst holds them idle
// Notes: ends through give_verdict
`timescale 1ns/1ps
`define CHK(a,b) begin samples_checked++; if ((a) !== (b)) begin \
    n_errors++; $display("[ERR] %0t %h %h", $time, a, b); end end
module ipr_prio_reg6_tb_top;
    logic clk_sys = 0, nrst = 0, hsel = 0, hwrite = 0;
    logic [31:0] haddr = 0, hwdata = 0, rd;
    logic [1:0] htrans = 0;
    logic [3:0] pend = 4'hF;
    wire hready, hrsp;
    wire [31:0] hrdata;
    wire [2:0] txP, rxP, exP, tmP;
    wire [3:0] req;
    int n_errors = 0, samples_checked = 0;
    ipr_prio_reg6 dut_u (.clk_sys(clk_sys), .nrst(nrst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hrsp),
        .hrdata(hrdata), .txPending(pend[3]), .rxPending(pend[2]),
        .ext2Pending(pend[1]), .tmr5Pending(pend[0]),
        .serial2TxIrqPriority(txP), .serial2RxIrqPriority(rxP),
        .extInput2IrqPriority(exP), .timer5IrqPriority(tmP),
        .txRequest(req[3]), .rxRequest(req[2]), .ext2Request(req[1]),
        .tmr5Request(req[0]));
    // 100 MHz clock
    initial forever #5 clk_sys = ~clk_sys;
    task give_verdict;
        if (n_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // bounded wait for hready at a rising edge
    task wt;
        int k;
        k = 0;
        do begin @(posedge clk_sys); k++; end while (hready !== 1'b1 && k < 64);
        if (hready !== 1'b1) begin n_errors++; give_verdict; end
    endtask
    // one single word transfer, read data left in rd
    task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= a;
        wt;
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
        wt;
        rd = hrdata;
    endtask
    task t_reset;
        bus(0, 32'h0, 32'h0);
        `CHK(rd, 32'h00004444)
        `CHK({txP, rxP, exP, tmP}, 12'h924)
    endtask
    task t_codes;
        for (int c = 0; c < 8; c++) begin
            bus(1, 32'h0, 32'hFFFF8888 | (32'h1111 * c));
            bus(0, 32'h0, 32'h0);
            `CHK(rd, 32'h1111 * c)
            `CHK(rxP, 3'(c))
            `CHK(req, {4{c != 0}})
        end
    endtask
    task t_unmap;
        bus(1, 32'h4, 32'h0);
        `CHK(hrsp, 1'b0)
        bus(0, 32'h4, 32'h0);
        `CHK(rd, 32'h0)
        bus(0, 32'h0, 32'h0);
        `CHK(rd, 32'h00007777)
    endtask
    // sources idle, then a reset in mid-run
    task t_gate_rst;
        pend <= 4'h0;
        @(posedge clk_sys);
        `CHK(req, 4'h0)
        pend <= 4'hF;
        nrst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        nrst <= 1'b1;
        bus(0, 32'h0, 32'h0);
        `CHK(rd, 32'h00004444)
    endtask
    // reset for 20 cycles, then the scenarios
    initial begin
        repeat (20) @(posedge clk_sys);
        nrst <= 1'b1;
        t_reset;
        t_codes;
        t_unmap;
        t_gate_rst;
        give_verdict;
    end
endmodule // ipr_prio_reg6_tb_top
